// *** src/rphc_ctrl.sv ***
// rphc_ctrl: chip control byte bits 4 and 5 with upstream read policy and
// transaction acceptance gating
// assumes: config byte write strobe and target requests are core_clk pulses,
// the hot-insert pin arrives asynchronously
//
// Operation
// - with bit 4 clear, upstream memory reads prefetch and byte enables are not forwarded.
// - with bit 4 set, the requester's byte enables go to the target on plain memory reads.
// - with bit 4 set, a plain memory read fetches one Dword and no more.
// - with bit 4 set, the plain memory read is ended with a disconnect on the first data.
// - memory read line and read multiple stay prefetchable whatever bit 4 holds.
// - with bit 5 clear, the hot-insert pin has no effect on the enables.
// - masking happens only while the pin is set input-only, besides bit 5 set.
// - with bit 5 set and the pin input-only, a high pin forces the effective enables to zero.
// - while masked, no I/O or memory transaction is accepted.
// - bits 7:6 are reserved, ignore writes and read as zero.
`timescale 1ns/100ps
module rphc_ctrl (
  input  wire logic       core_clk,
  input  wire logic       reset_n,
  input  wire logic       cfg_wr,
  input  wire logic [7:0] cfg_wdata,
  output logic      [7:0] cfg_rdata,
  input  wire logic       io_en,
  input  wire logic       mem_en,
  input  wire logic       master_en,
  input  wire logic       hot_pin_oe,
  input  wire logic       hot_pin_in,
  output logic            io_en_eff,
  output logic            mem_en_eff,
  output logic            master_en_eff,
  input  wire logic       up_rd_req,
  input  wire logic [3:0] up_rd_cmd,
  input  wire logic [3:0] up_rd_be_n,
  output logic            rd_valid,
  output logic            rd_prefetch,
  output logic            rd_fwd_be,
  output logic      [3:0] rd_be_n,
  output logic            rd_single,
  output logic            rd_disc_first,
  input  wire logic       tgt_req,
  input  wire logic [3:0] tgt_cmd,
  output logic            tgt_accept,
  output logic            tgt_refuse
);
  logic                nonpf_r;
  logic                live_r;
  logic                hot_mask;
  logic                rd_valid_r;
  logic                rd_prefetch_r;
  logic                rd_fwd_be_r;
  logic [3:0]          rd_be_n_r;
  logic                rd_single_r;
  logic                rd_disc_r;
  logic                plain_rd;
  logic                multi_rd;
  rphc_pkg::rphc_cls_t tgt_cls;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      nonpf_r <= rphc_pkg::CTRL_RESET[rphc_pkg::NONPF_BIT];
      live_r  <= rphc_pkg::CTRL_RESET[rphc_pkg::LIVE_BIT];
    end else if (cfg_wr) begin
      nonpf_r <= cfg_wdata[rphc_pkg::NONPF_BIT];
      live_r  <= cfg_wdata[rphc_pkg::LIVE_BIT];
    end
  end

  // only the two live bits are read back, the reserved field is zero
  assign cfg_rdata = {2'h0, live_r, nonpf_r, 4'h0} & rphc_pkg::CTRL_WMASK;

  rphc_hot_mask u_hot_mask (
    .core_clk      (core_clk),
    .reset_n       (reset_n),
    .live_ins      (live_r),
    .hot_pin_oe    (hot_pin_oe),
    .hot_pin_in    (hot_pin_in),
    .io_en         (io_en),
    .mem_en        (mem_en),
    .master_en     (master_en),
    .io_en_eff     (io_en_eff),
    .mem_en_eff    (mem_en_eff),
    .master_en_eff (master_en_eff),
    .hot_mask      (hot_mask)
  );

  assign plain_rd = (up_rd_cmd == rphc_pkg::CMD_MEM_READ);
  assign multi_rd = (up_rd_cmd == rphc_pkg::CMD_MEM_RDLINE)
                 || (up_rd_cmd == rphc_pkg::CMD_MEM_RDMULT);

  // read policy decided once per upstream read request, held until the next
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_valid_r <= 1'b0;
    end else begin
      rd_valid_r <= up_rd_req && (plain_rd || multi_rd);
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_prefetch_r <= 1'b0;
      rd_fwd_be_r   <= 1'b0;
      rd_be_n_r     <= 4'hF;
      rd_single_r   <= 1'b0;
      rd_disc_r     <= 1'b0;
    end else if (up_rd_req && (plain_rd || multi_rd)) begin
      if (multi_rd || !nonpf_r) begin
        rd_prefetch_r <= 1'b1;
        rd_fwd_be_r   <= 1'b0;
        rd_be_n_r     <= 4'h0;
        rd_single_r   <= 1'b0;
        rd_disc_r     <= 1'b0;
      end else begin
        rd_prefetch_r <= 1'b0;
        rd_fwd_be_r   <= 1'b1;
        rd_be_n_r     <= up_rd_be_n;
        rd_single_r   <= (rphc_pkg::SINGLE_DWORDS == 1);
        rd_disc_r     <= 1'b1;
      end
    end
  end

  assign rd_valid      = rd_valid_r;
  assign rd_prefetch   = rd_prefetch_r;
  assign rd_fwd_be     = rd_fwd_be_r;
  assign rd_be_n       = rd_be_n_r;
  assign rd_single     = rd_single_r;
  assign rd_disc_first = rd_disc_r;

  always_comb begin
    if ((tgt_cmd == rphc_pkg::CMD_IO_READ) || (tgt_cmd == rphc_pkg::CMD_IO_WRITE)) begin
      tgt_cls = rphc_pkg::RPHC_CLS_IO;
    end else if ((tgt_cmd == rphc_pkg::CMD_MEM_READ) || (tgt_cmd == rphc_pkg::CMD_MEM_WRITE)
              || (tgt_cmd == rphc_pkg::CMD_MEM_RDMULT) || (tgt_cmd == rphc_pkg::CMD_MEM_RDLINE)
              || (tgt_cmd == rphc_pkg::CMD_MEM_WRINV)) begin
      tgt_cls = rphc_pkg::RPHC_CLS_MEM;
    end else begin
      tgt_cls = rphc_pkg::RPHC_CLS_NONE;
    end
  end

  // effective enables already carry the mask, so a masked bridge refuses all I/O and memory commands
  assign tgt_accept = tgt_req && (((tgt_cls == rphc_pkg::RPHC_CLS_IO) && io_en_eff)
                   || ((tgt_cls == rphc_pkg::RPHC_CLS_MEM) && mem_en_eff));
  assign tgt_refuse = tgt_req && (tgt_cls != rphc_pkg::RPHC_CLS_NONE) && !tgt_accept;

  property p_prefetch_default;
    @(posedge core_clk) disable iff (!reset_n)
      (up_rd_req && plain_rd && !nonpf_r) |=> rd_valid && rd_prefetch && !rd_fwd_be;
  endproperty
  a_prefetch_default: assert property (p_prefetch_default)
    else $error("plain read not prefetched with bit 4 clear");

  property p_fwd_be;
    @(posedge core_clk) disable iff (!reset_n)
      (up_rd_req && plain_rd && nonpf_r) |=> rd_fwd_be && (rd_be_n == $past(up_rd_be_n));
  endproperty
  a_fwd_be: assert property (p_fwd_be)
    else $error("byte enables not forwarded with bit 4 set");

  property p_single;
    @(posedge core_clk) disable iff (!reset_n)
      (up_rd_req && plain_rd && nonpf_r) |=> rd_single && !rd_prefetch;
  endproperty
  a_single: assert property (p_single)
    else $error("non-prefetch read not limited to one dword");

  property p_disc;
    @(posedge core_clk) disable iff (!reset_n)
      (up_rd_req && plain_rd && nonpf_r) |=> rd_disc_first ##1 (rd_disc_first || $past(up_rd_req));
  endproperty
  a_disc: assert property (p_disc)
    else $error("disconnect on first data missing or dropped");

  property p_multi_pf;
    @(posedge core_clk) disable iff (!reset_n)
      (up_rd_req && multi_rd) |=> rd_prefetch && !rd_disc_first && !rd_single;
  endproperty
  a_multi_pf: assert property (p_multi_pf)
    else $error("line or multiple read lost prefetch");

  property p_refuse_masked;
    @(posedge core_clk) disable iff (!reset_n)
      (tgt_req && hot_mask && (tgt_cls != rphc_pkg::RPHC_CLS_NONE)) |-> !tgt_accept && tgt_refuse;
  endproperty
  a_refuse_masked: assert property (p_refuse_masked)
    else $error("transaction accepted while masked");

  property p_rsvd_zero;
    @(posedge core_clk) disable iff (!reset_n)
      cfg_wr |=> (cfg_rdata[rphc_pkg::RSVD_HI:rphc_pkg::RSVD_LO] == 2'h0)
                 && (cfg_rdata[5:4] == $past(cfg_wdata[5:4]));
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero)
    else $error("reserved bits not zero or live bits not stored");

  property p_live_mask_needs_bit;
    @(posedge core_clk) disable iff (!reset_n)
      (!live_r && io_en && mem_en && tgt_req && (tgt_cls == rphc_pkg::RPHC_CLS_MEM)) |-> tgt_accept;
  endproperty
  a_live_mask_needs_bit: assert property (p_live_mask_needs_bit)
    else $error("memory transaction refused with live insertion off");

  // prefetching reads claim all byte lanes and carry no single or disconnect marks
  property p_pf_be_zero;
    @(posedge core_clk) disable iff (!reset_n)
      (up_rd_req && (multi_rd || (plain_rd && !nonpf_r)))
      |=> (rd_be_n == 4'h0) && !rd_single && !rd_disc_first;
  endproperty
  a_pf_be_zero: assert property (p_pf_be_zero)
    else $error("prefetching read kept byte enables or single marks");

  property p_other_rd_ignored;
    @(posedge core_clk) disable iff (!reset_n)
      (up_rd_req && !plain_rd && !multi_rd) |=> !rd_valid;
  endproperty
  a_other_rd_ignored: assert property (p_other_rd_ignored)
    else $error("non-read command produced a read decision");

  property p_rsvd_idle;
    @(posedge core_clk) disable iff (!reset_n)
      (cfg_rdata[rphc_pkg::RSVD_HI:rphc_pkg::RSVD_LO] == 2'h0) && (cfg_rdata[3:0] == 4'h0);
  endproperty
  a_rsvd_idle: assert property (p_rsvd_idle)
    else $error("reserved or foreign bits read non-zero");

  // with no mask the programmed enables pass straight through
  property p_unmasked_pass;
    @(posedge core_clk) disable iff (!reset_n)
      !hot_mask |-> (io_en_eff == io_en) && (mem_en_eff == mem_en)
                    && (master_en_eff == master_en);
  endproperty
  a_unmasked_pass: assert property (p_unmasked_pass)
    else $error("enables altered while not masked");
endmodule : rphc_ctrl

// *** src/rphc_pkg.sv ***
// rphc_pkg: constants for the read prefetch and hot insert control block
// assumes: PCI command codes on a 4-bit bus, control byte reached as one config byte
package rphc_pkg;
  localparam int          NONPF_BIT      = 4;
  localparam int          LIVE_BIT       = 5;
  localparam int          RSVD_HI        = 7;
  localparam int          RSVD_LO        = 6;
  localparam logic [7:0]  CTRL_RESET     = 8'h00;
  localparam logic [7:0]  CTRL_WMASK     = 8'h30;
  localparam int          SINGLE_DWORDS  = 1;
  localparam int          SYNC_STAGES    = 2;
  localparam logic [3:0]  CMD_IO_READ    = 4'h2;
  localparam logic [3:0]  CMD_IO_WRITE   = 4'h3;
  localparam logic [3:0]  CMD_MEM_READ   = 4'h6;
  localparam logic [3:0]  CMD_MEM_WRITE  = 4'h7;
  localparam logic [3:0]  CMD_MEM_RDMULT = 4'hC;
  localparam logic [3:0]  CMD_MEM_RDLINE = 4'hE;
  localparam logic [3:0]  CMD_MEM_WRINV  = 4'hF;

  typedef enum logic [1:0] {
    RPHC_CLS_NONE = 2'b00,
    RPHC_CLS_IO   = 2'b01,
    RPHC_CLS_MEM  = 2'b10
  } rphc_cls_t;
endpackage : rphc_pkg

// *** src/rphc_hot_mask.sv ***
// rphc_hot_mask: synchronises the hot-insert pin and masks the command enables
// assumes: stored enables and the pin direction control come from core_clk logic
`timescale 1ns/100ps
module rphc_hot_mask (
  input  wire logic core_clk,
  input  wire logic reset_n,
  input  wire logic live_ins,
  input  wire logic hot_pin_oe,
  input  wire logic hot_pin_in,
  input  wire logic io_en,
  input  wire logic mem_en,
  input  wire logic master_en,
  output logic      io_en_eff,
  output logic      mem_en_eff,
  output logic      master_en_eff,
  output logic      hot_mask
);
  logic [rphc_pkg::SYNC_STAGES-1:0] pin_sync_r;
  logic                             pin_s;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_sync_r <= '0;
    end else begin
      pin_sync_r <= {pin_sync_r[rphc_pkg::SYNC_STAGES-2:0], hot_pin_in};
    end
  end

  assign pin_s = pin_sync_r[rphc_pkg::SYNC_STAGES-1];

  // mask acts only with live insertion on and the pin set input-only
  assign hot_mask      = live_ins && !hot_pin_oe && pin_s;
  // stored enables untouched, only the effective copies are gated
  assign io_en_eff     = io_en && !hot_mask;
  assign mem_en_eff    = mem_en && !hot_mask;
  assign master_en_eff = master_en && !hot_mask;

  property p_pin_forces_zero;
    @(posedge core_clk) disable iff (!reset_n)
      (live_ins && !hot_pin_oe && $past(hot_pin_in, 2) && $past(hot_pin_in, 1) && reset_n
       && $past(reset_n, 2))
      |-> !io_en_eff && !mem_en_eff && !master_en_eff;
  endproperty
  a_pin_forces_zero: assert property (p_pin_forces_zero)
    else $error("hot pin high did not clear effective enables");

  property p_live_off;
    @(posedge core_clk) disable iff (!reset_n)
      !live_ins |-> (io_en_eff == io_en) && (mem_en_eff == mem_en)
                    && (master_en_eff == master_en);
  endproperty
  a_live_off: assert property (p_live_off)
    else $error("pin influenced enables with live insertion off");

  property p_output_dir;
    @(posedge core_clk) disable iff (!reset_n)
      hot_pin_oe |-> !hot_mask && (io_en_eff == io_en);
  endproperty
  a_output_dir: assert property (p_output_dir)
    else $error("mask applied while pin is driven as output");

  property p_restore;
    @(posedge core_clk) disable iff (!reset_n)
      ($past(hot_mask) && !hot_mask) |-> (mem_en_eff == mem_en) && (master_en_eff == master_en);
  endproperty
  a_restore: assert property (p_restore)
    else $error("programmed enables not restored after mask");
endmodule : rphc_hot_mask

// *** verification/rphc_far_model.sv ***
// rphc_far_model: card side of the hot-insert pin, level changes off the clock grid
// assumes: card_in is a level from the bench, the pin rests low
`timescale 1ns/100ps
module rphc_far_model (
  input  wire logic card_in,
  output logic      hot_pin
);
  initial hot_pin = 1'b0;
  always @(card_in) hot_pin <= #1.3 card_in;
endmodule : rphc_far_model

// *** verification/read_prefetch_and_hot_insert_control_tb.sv ***
// read_prefetch_and_hot_insert_control_tb: self-checking bench for rphc_ctrl
// assumes: rphc_pkg compiled first, inputs driven on the falling edge
`timescale 1ns/100ps
module read_prefetch_and_hot_insert_control_tb;
  logic       core_clk, reset_n, cfg_wr, io_en, mem_en, master_en, hot_pin_oe;
  logic       hot_pin_in, card_in, up_rd_req, tgt_req, rd_valid, rd_prefetch;
  logic       rd_fwd_be, rd_single, rd_disc_first, tgt_accept, tgt_refuse;
  logic       io_en_eff, mem_en_eff, master_en_eff, msk;
  logic [7:0] cfg_wdata, cfg_rdata, ctrl_exp;
  logic [3:0] up_rd_cmd, up_rd_be_n, rd_be_n, tgt_cmd;
  logic [2:0] en_exp;
  logic [7:0] exp_q[$];
  logic [3:0] cmds[5];
  int         err_count, n_compared;

  rphc_ctrl rphc_ctrl_i (
    .core_clk(core_clk), .reset_n(reset_n), .cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata),
    .cfg_rdata(cfg_rdata), .io_en(io_en), .mem_en(mem_en), .master_en(master_en),
    .hot_pin_oe(hot_pin_oe), .hot_pin_in(hot_pin_in), .io_en_eff(io_en_eff),
    .mem_en_eff(mem_en_eff), .master_en_eff(master_en_eff), .up_rd_req(up_rd_req),
    .up_rd_cmd(up_rd_cmd), .up_rd_be_n(up_rd_be_n), .rd_valid(rd_valid),
    .rd_prefetch(rd_prefetch), .rd_fwd_be(rd_fwd_be), .rd_be_n(rd_be_n),
    .rd_single(rd_single), .rd_disc_first(rd_disc_first), .tgt_req(tgt_req),
    .tgt_cmd(tgt_cmd), .tgt_accept(tgt_accept), .tgt_refuse(tgt_refuse)
  );
  rphc_far_model rphc_far_model_i (.card_in(card_in), .hot_pin(hot_pin_in));

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic give_verdict;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : give_verdict

  task automatic cfg_write(input logic [7:0] d);
    cfg_wr = 1'b1;
    cfg_wdata = d;
    @(negedge core_clk);
    cfg_wr = 1'b0;
    ctrl_exp = d & rphc_pkg::CTRL_WMASK;
    // a clock passes with the strobe low before a following write raises it
    @(negedge core_clk);
    check("cfg_rdata", cfg_rdata, ctrl_exp);
  endtask : cfg_write

  // non-prefetch only for plain reads with bit 4 set; line and multiple always prefetch
  task automatic up_read(input logic [3:0] cmd, input logic [3:0] be);
    up_rd_req = 1'b1;
    up_rd_cmd = cmd;
    up_rd_be_n = be;
    if (cmd == rphc_pkg::CMD_MEM_READ && ctrl_exp[rphc_pkg::NONPF_BIT])
      exp_q.push_back({4'h7, be});
    else if (cmd inside {rphc_pkg::CMD_MEM_READ, rphc_pkg::CMD_MEM_RDMULT,
                         rphc_pkg::CMD_MEM_RDLINE})
      exp_q.push_back(8'h80);
    @(negedge core_clk);
  endtask : up_read

  always @(negedge core_clk) if (rd_valid === 1'b1) begin
    if (exp_q.size() == 0) check("rd_extra", 8'h01, 8'h00);
    else check("rd_decision", {rd_prefetch, rd_fwd_be, rd_single, rd_disc_first, rd_be_n},
               exp_q.pop_front());
  end

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  initial begin
    #100us;
    err_count++;
    give_verdict();
  end

  initial begin
    {reset_n, cfg_wr, up_rd_req, tgt_req, card_in, hot_pin_oe} = 6'h00;
    {io_en, mem_en, master_en} = 3'h7;
    {cfg_wdata, ctrl_exp} = 16'h0000;
    {up_rd_cmd, up_rd_be_n, tgt_cmd} = 12'h0F0;
    cmds = '{rphc_pkg::CMD_MEM_READ, rphc_pkg::CMD_MEM_RDMULT, rphc_pkg::CMD_MEM_RDLINE,
             rphc_pkg::CMD_MEM_WRITE, rphc_pkg::CMD_MEM_READ};
    err_count = 0;
    n_compared = 0;
    void'($urandom(44));
    repeat (16) @(negedge core_clk);
    reset_n = 1'b1;
    @(negedge core_clk);
    check("cfg_reset", cfg_rdata, rphc_pkg::CTRL_RESET);
    check("en_reset", 8'({io_en_eff, mem_en_eff, master_en_eff}), 8'h07);
    $display("reset test done");
    cfg_write(8'hFF);
    cfg_write(8'hC0);
    cfg_write(8'($urandom));
    $display("config test done");
    for (int m = 0; m < 2; m++) begin
      cfg_write(m ? 8'hD0 : 8'h2F);
      foreach (cmds[i]) up_read(cmds[i], 4'($urandom));
      up_rd_req = 1'b0;
      repeat (2) @(negedge core_clk);
    end
    $display("read test done");
    for (int k = 0; k < 16; k++) begin
      cfg_write({2'h3, k[2], 5'h1F});
      // live bit from k[2], pin direction from k[1], card level from k[0]
      {hot_pin_oe, card_in} = k[1:0];
      {io_en, mem_en, master_en} = k[3] ? 3'($urandom) : 3'h7;
      repeat (4) @(negedge core_clk);
      msk = k[2] & ~k[1] & k[0];
      en_exp = {io_en, mem_en, master_en} & {3{~msk}};
      check("eff_en", 8'({io_en_eff, mem_en_eff, master_en_eff}), 8'(en_exp));
      tgt_req = 1'b1;
      tgt_cmd = rphc_pkg::CMD_IO_READ;
      @(negedge core_clk);
      check("tgt_io", 8'({tgt_accept, tgt_refuse}), 8'({en_exp[2], ~en_exp[2]}));
      tgt_cmd = rphc_pkg::CMD_MEM_WRITE;
      @(negedge core_clk);
      check("tgt_mem", 8'({tgt_accept, tgt_refuse}), 8'({en_exp[1], ~en_exp[1]}));
      tgt_req = 1'b0;
    end
    $display("hot insert test done");
    repeat (3) @(negedge core_clk);
    check("rd_missing", 8'(exp_q.size()), 8'h00);
    give_verdict();
  end
endmodule : read_prefetch_and_hot_insert_control_tb
